// ### design/boot_cfg_params.svh
`ifndef BOOT_CFG_PARAMS_SVH
`define BOOT_CFG_PARAMS_SVH
// configuration byte locations in the special-purpose area
`define CFG0_ADDR 24'h002018
`define CFG1_ADDR 24'h00201A
`define CFG2_ADDR 24'h00201C
// avalon register byte offsets
`define REG_CFG0 8'h00
`define REG_CFG1 8'h04
`define REG_CFG2 8'h08
`define REG_STATUS 8'h0C
`define REG_DECODE_ADDR 8'h10
`define REG_DECODE_RES 8'h14
`define REG_LOAD 8'h18
// byte zero fields
`define B0_POWERDOWN 0
`define B0_BUS_LO 1
`define B0_WR_STYLE 2
`define B0_ALE_STYLE 3
`define B0_WAIT_LIM0 4
`define B0_WAIT_LIM1 5
`define B0_PROT0 6
`define B0_PROT1 7
// byte one fields
`define B1_THIRD 0
`define B1_WAIT_LIM2 1
`define B1_BUS_HI 2
`define B1_WDOG 3
`define B1_TIMING0 6
`define B1_TIMING1 7
// byte two fields
`define B2_WIDE 1
`define B2_MIRROR 2
// reset values of the config shadows (erased part)
`define CFG_RESET 8'hFF
`define CFG2_DEFAULT 8'hFD
// unmapped read value
`define UNMAPPED_DATA 32'hDEADBEEF
`endif

// ### design/boot_cfg_pkg.sv
package boot_cfg_pkg;
    typedef enum logic [3:0] {
        LD_IDLE = 4'b0001,
        LD_REQ = 4'b0010,
        LD_WAIT = 4'b0100,
        LD_DONE = 4'b1000
    } load_state_t;
    // decode target codes
    typedef enum logic [3:0] {
        TGT_CPU_SFR = 4'h0,
        TGT_LOW_REG = 4'h1,
        TGT_UP_REG = 4'h2,
        TGT_CODE_RAM = 4'h3,
        TGT_EXT = 4'h4,
        TGT_REG_RAM = 4'h5,
        TGT_NET_MEM = 4'h6,
        TGT_PERIPH_SFR = 4'h7,
        TGT_MM_SFR = 4'h8,
        TGT_PROG_INT = 4'h9,
        TGT_SPECIAL_INT = 4'hA,
        TGT_ICE = 4'hB
    } target_t;
endpackage

// ### design/boot_config_and_address_decode.sv
`timescale 1ns/1ns
`include "boot_cfg_params.svh"
// Contract
// - top RAM window mirrors low RAM window
// - large package overlay aliases to page 15
// - low code internal only if low_segment_mirror and pin
// - fetches below 0400H always go external
// - top program area follows external pin
// - 1C00H-1FFFH decode to internal regions
// - register file split with addressing limits
// - byte zero bit 2 picks write strobes
// - byte zero bit 3 picks address strobe
// - bits 7:6 encode code protection
// - bus timing mode 0 or 3 only
// - three bits cap inserted wait states
// - bus width fixed or pin controlled
// - watchdog bit zero locks watchdog on
// - byte one bit 0 fetches byte two
// - byte two bit 1 picks address width
// - byte two bit 2 mirrors segment 00H
module boot_config_and_address_decode (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [23:0] cpu_addr,
    input wire logic cpu_fetch,
    input wire logic cpu_direct,
    input wire logic large_package,
    input wire logic external_fetch_pin,
    input wire logic powerdown_req,
    input wire logic watchdog_disable_req,
    output logic [3:0] target,
    output logic addr_fault,
    output logic [23:0] ext_addr,
    output logic cfg_rd_req,
    output logic [23:0] cfg_rd_addr,
    input wire logic cfg_rd_valid,
    input wire logic [7:0] cfg_rd_data,
    output logic cfg_done,
    output logic single_write_strobe,
    output logic addr_latch_pulse,
    output logic read_protect,
    output logic write_protect,
    output logic [2:0] wait_limit,
    output logic wait_unlimited,
    output logic bus_timing_mode3,
    output logic bus_16_fixed,
    output logic bus_8_fixed,
    output logic bus_pin_sized,
    output logic bus_code_bad,
    output logic watchdog_locked,
    output logic watchdog_run,
    output logic addr_wide,
    output logic powerdown_go
);
    // ======================================================
    // pin synchroniser
    // ======================================================
    logic [2:0] pin_sync_r;
    logic pin_level_r;
    // three stages, change taken when second and third agree
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_sync_r <= 3'h0;
            pin_level_r <= 1'b0;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], external_fetch_pin};
            if (pin_sync_r[1] == pin_sync_r[2]) begin
                pin_level_r <= pin_sync_r[2];
            end
        end
    end

    // ======================================================
    // configuration loader
    // ======================================================
    boot_cfg_pkg::load_state_t state_r;
    logic [1:0] idx_r;
    logic [7:0] cfg0_r, cfg1_r, cfg2_r;
    // bytes fetched once after reset and then frozen
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= boot_cfg_pkg::LD_IDLE;
            idx_r <= 2'h0;
            cfg0_r <= `CFG_RESET;
            cfg1_r <= `CFG_RESET;
            cfg2_r <= `CFG2_DEFAULT;
        end else begin
            case (state_r)
                boot_cfg_pkg::LD_IDLE: begin
                    state_r <= boot_cfg_pkg::LD_REQ;
                end
                boot_cfg_pkg::LD_REQ: begin
                    state_r <= boot_cfg_pkg::LD_WAIT;
                end
                boot_cfg_pkg::LD_WAIT: begin
                    if (cfg_rd_valid) begin
                        if (idx_r == 2'h0) begin
                            cfg0_r <= cfg_rd_data;
                            idx_r <= 2'h1;
                            state_r <= boot_cfg_pkg::LD_REQ;
                        end else if (idx_r == 2'h1) begin
                            cfg1_r <= cfg_rd_data;
                            idx_r <= 2'h2;
                            // third byte only when asked for
                            state_r <= cfg_rd_data[`B1_THIRD] ? boot_cfg_pkg::LD_REQ
                                                               : boot_cfg_pkg::LD_DONE;
                        end else begin
                            cfg2_r <= cfg_rd_data;
                            state_r <= boot_cfg_pkg::LD_DONE;
                        end
                    end
                end
                boot_cfg_pkg::LD_DONE: begin
                    state_r <= boot_cfg_pkg::LD_DONE;
                end
                default: begin
                    state_r <= boot_cfg_pkg::LD_IDLE;
                end
            endcase
        end
    end

    assign cfg_rd_req = (state_r == boot_cfg_pkg::LD_REQ);
    assign cfg_rd_addr = (idx_r == 2'h0) ? `CFG0_ADDR : (idx_r == 2'h1) ? `CFG1_ADDR : `CFG2_ADDR;
    assign cfg_done = (state_r == boot_cfg_pkg::LD_DONE);

    // ======================================================
    // decoded settings
    // ======================================================
    assign single_write_strobe = cfg0_r[`B0_WR_STYLE];
    assign addr_latch_pulse = cfg0_r[`B0_ALE_STYLE];
    // 00 both, 01 write only, 10 read only, 11 none
    assign read_protect = ~cfg0_r[`B0_PROT0];
    // only the high protection bit decides write protection
    assign write_protect = ~cfg0_r[`B0_PROT1];
    logic [2:0] irc;
    assign irc = {cfg1_r[`B1_WAIT_LIM2], cfg0_r[`B0_WAIT_LIM1], cfg0_r[`B0_WAIT_LIM0]};
    // 000 zero, 100 one, 101 two, 110 three, 111 unlimited
    always_comb begin
        wait_unlimited = 1'b0;
        if (irc == 3'h4) begin
            wait_limit = 3'h1;
        end else if (irc == 3'h5) begin
            wait_limit = 3'h2;
        end else if (irc == 3'h6) begin
            wait_limit = 3'h3;
        end else if (irc == 3'h7) begin
            wait_limit = 3'h7;
            wait_unlimited = 1'b1;
        end else begin
            wait_limit = 3'h0;
        end
    end
    // mode 0 (one automatic wait) unless both select bits set
    assign bus_timing_mode3 = cfg1_r[`B1_TIMING1] & cfg1_r[`B1_TIMING0];
    logic [1:0] bw;
    assign bw = {cfg1_r[`B1_BUS_HI], cfg0_r[`B0_BUS_LO]};
    assign bus_16_fixed = (bw == 2'h1);
    assign bus_8_fixed = (bw == 2'h2);
    assign bus_pin_sized = (bw == 2'h3);
    assign bus_code_bad = (bw == 2'h0);
    assign watchdog_locked = ~cfg1_r[`B1_WDOG];
    assign watchdog_run = watchdog_locked | ~watchdog_disable_req;
    assign addr_wide = cfg2_r[`B2_WIDE];
    assign powerdown_go = powerdown_req & cfg0_r[`B0_POWERDOWN] & cfg_done;

    // ======================================================
    // address decoder
    // ======================================================
    logic [3:0] tgt;
    logic [23:0] eaddr;
    logic fault;
    logic [15:0] lo;
    logic top_seg, low_seg, mirror;
    assign lo = cpu_addr[15:0];
    assign top_seg = (cpu_addr[23:16] == 8'hFF);
    assign low_seg = (cpu_addr[23:16] == 8'h00);
    assign mirror = cfg2_r[`B2_MIRROR] & pin_level_r;
    always_comb begin
        tgt = boot_cfg_pkg::TGT_EXT;
        eaddr = addr_wide ? cpu_addr : {8'h00, lo};
        fault = 1'b0;
        if (top_seg && lo >= 16'h2080) begin
            tgt = pin_level_r ? boot_cfg_pkg::TGT_PROG_INT : boot_cfg_pkg::TGT_EXT;
        end else if (top_seg && lo >= 16'h2000) begin
            tgt = pin_level_r ? boot_cfg_pkg::TGT_SPECIAL_INT : boot_cfg_pkg::TGT_EXT;
        end else if (top_seg && lo >= 16'h0400 && lo <= 16'h05FF) begin
            tgt = boot_cfg_pkg::TGT_CODE_RAM;
        end else if (top_seg && lo <= 16'h00FF) begin
            tgt = boot_cfg_pkg::TGT_ICE;
        end else if (top_seg) begin
            tgt = boot_cfg_pkg::TGT_EXT;
        end else if (!low_seg) begin
            // overlay region folds onto page 15 on the large package
            if (large_package && cpu_addr >= 24'h0F0000) begin
                eaddr = {8'h0F, lo};
            end
        end else if (lo >= 16'h2000) begin
            if (mirror) begin
                tgt = lo >= 16'h2080 ? boot_cfg_pkg::TGT_PROG_INT : boot_cfg_pkg::TGT_SPECIAL_INT;
            end
        end else if (lo >= 16'h1FE0) begin
            tgt = boot_cfg_pkg::TGT_MM_SFR;
        end else if (lo >= 16'h1F00) begin
            tgt = boot_cfg_pkg::TGT_PERIPH_SFR;
        end else if (lo >= 16'h1E00) begin
            tgt = boot_cfg_pkg::TGT_NET_MEM;
        end else if (lo >= 16'h1C00) begin
            tgt = boot_cfg_pkg::TGT_REG_RAM;
        end else if (lo >= 16'h0600) begin
            tgt = boot_cfg_pkg::TGT_EXT;
        end else if (lo >= 16'h0400) begin
            tgt = boot_cfg_pkg::TGT_CODE_RAM;
        end else if (cpu_fetch) begin
            tgt = boot_cfg_pkg::TGT_EXT;
        end else if (lo >= 16'h0100) begin
            tgt = boot_cfg_pkg::TGT_UP_REG;
            fault = cpu_direct;
        end else if (lo >= 16'h0018) begin
            tgt = boot_cfg_pkg::TGT_LOW_REG;
        end else begin
            tgt = boot_cfg_pkg::TGT_CPU_SFR;
        end
    end

    // registered decode result
    always_ff @(posedge clk) begin
        if (reset) begin
            target <= 4'h4;
            ext_addr <= 24'h000000;
            addr_fault <= 1'b0;
        end else begin
            target <= tgt;
            ext_addr <= eaddr;
            addr_fault <= fault;
        end
    end

    // ======================================================
    // avalon slave
    // ======================================================
    logic [31:0] rdata_nxt;
    logic busy_r;
    // one wait cycle per access, answer on the second edge
    always_ff @(posedge clk) begin
        if (reset) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (avs_read | avs_write) & ~busy_r;
        end
    end
    assign avs_waitrequest = (avs_read | avs_write) & ~busy_r;
    always_comb begin
        if (avs_address == `REG_CFG0) begin
            rdata_nxt = {24'h000000, cfg0_r};
        end else if (avs_address == `REG_CFG1) begin
            rdata_nxt = {24'h000000, cfg1_r};
        end else if (avs_address == `REG_CFG2) begin
            rdata_nxt = {24'h000000, cfg2_r};
        end else if (avs_address == `REG_STATUS) begin
            rdata_nxt = {26'h0, pin_level_r, watchdog_locked, bus_code_bad, bus_timing_mode3,
                         addr_wide, cfg_done};
        end else begin
            rdata_nxt = `UNMAPPED_DATA;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            avs_readdata <= 32'h00000000;
        end else begin
            avs_readdata <= rdata_nxt;
        end
    end

    // ======================================================
    // checks
    // ======================================================
    a_cfg_frozen: assert property (@(posedge clk) disable iff (reset)
        cfg_done |=> $stable(cfg0_r) && $stable(cfg1_r) && $stable(cfg2_r))
        else $error("config changed after load");
    a_no_third: assert property (@(posedge clk) disable iff (reset)
        state_r == boot_cfg_pkg::LD_WAIT && cfg_rd_valid && idx_r == 2'h1 && !cfg_rd_data[0]
        |=> cfg_done)
        else $error("third byte fetched while disabled");
    a_fetch_ext: assert property (@(posedge clk) disable iff (reset)
        cpu_fetch && cpu_addr < 24'h000400 |=> target == 4'h4)
        else $error("low fetch not external");
    a_top_mirror: assert property (@(posedge clk) disable iff (reset)
        cpu_addr >= 24'hFF0400 && cpu_addr <= 24'hFF05FF |=> target == 4'h3)
        else $error("top ram window misdecoded");
    a_overlay: assert property (@(posedge clk) disable iff (reset)
        large_package && addr_wide && cpu_addr >= 24'h0F0000 && cpu_addr < 24'hFF0000
        |=> ext_addr[23:16] == 8'h0F)
        else $error("overlay not aliased");
    a_net_mem: assert property (@(posedge clk) disable iff (reset)
        cpu_addr >= 24'h001E00 && cpu_addr <= 24'h001EFF |=> target == 4'h6)
        else $error("network memory misdecoded");
    a_wdog_lock: assert property (@(posedge clk) disable iff (reset)
        cfg_done && !cfg1_r[3] |-> watchdog_run)
        else $error("locked watchdog stopped");
    a_powerdown_block: assert property (@(posedge clk) disable iff (reset)
        !cfg0_r[0] |-> !powerdown_go)
        else $error("powerdown not blocked");
    a_wait_cap: assert property (@(posedge clk) disable iff (reset)
        irc == 3'h6 |-> wait_limit == 3'h3 && !wait_unlimited)
        else $error("wait cap wrong");
    a_low_segment_mirror_low: assert property (@(posedge clk) disable iff (reset)
        cpu_addr >= 24'h002080 && cpu_addr <= 24'h00FFFF && !mirror |=> target == 4'h4)
        else $error("low code not external");
endmodule

// ### tb/cfg_rom_model.sv
`timescale 1ns/1ns
// ==========================================
// configuration memory behind the loader
module cfg_rom_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic [7:0] b0,
    input wire logic [7:0] b1,
    input wire logic [7:0] b2,
    input wire logic cfg_rd_req,
    input wire logic [23:0] cfg_rd_addr,
    output logic cfg_rd_valid,
    output logic [7:0] cfg_rd_data,
    output int n_req
);
    logic pend;
    logic [1:0] cnt;
    logic [23:0] addr_q;
    initial begin
        cfg_rd_valid = 1'b0;
        cfg_rd_data = 8'h00;
    end
    // answers each request promptly or slowly; data toggles while idle
    always @(posedge clk) begin
        cfg_rd_valid <= 1'b0;
        cfg_rd_data <= ~cfg_rd_data;
        if (reset) begin
            pend <= 1'b0;
            n_req <= 0;
        end else if (cfg_rd_req) begin
            pend <= 1'b1;
            cnt <= slow ? 2'h3 : 2'h0;
            addr_q <= cfg_rd_addr;
            n_req <= n_req + 1;
        end else if (pend && cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
        end else if (pend) begin
            pend <= 1'b0;
            cfg_rd_valid <= 1'b1;
            case (addr_q)
                24'h002018: cfg_rd_data <= b0;
                24'h00201A: cfg_rd_data <= b1;
                24'h00201C: cfg_rd_data <= b2;
                default: cfg_rd_data <= 8'hFF;
            endcase
        end
    end
endmodule

// ### tb/test_boot_config_and_address_decode.sv
`timescale 1ns/1ns
// ==========================================
// bench for the boot loader and address decoder
module test_boot_config_and_address_decode;
    logic clk, reset, avs_read, avs_write, avs_waitrequest, slow;
    logic [7:0] avs_address, cfg_rd_data, b0, b1, b2;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable, target;
    logic [23:0] cpu_addr, ext_addr, cfg_rd_addr;
    logic cpu_fetch, cpu_direct, large_package, external_fetch_pin, powerdown_req, watchdog_disable_req;
    logic addr_fault, cfg_rd_req, cfg_rd_valid, cfg_done, single_write_strobe, addr_latch_pulse;
    logic read_protect, write_protect, wait_unlimited, bus_timing_mode3, bus_16_fixed, bus_8_fixed;
    logic bus_pin_sized, bus_code_bad, watchdog_locked, watchdog_run, addr_wide, powerdown_go;
    logic [2:0] wait_limit;
    int n_req, n_errors, cmp_count, cycles;
    logic [2:0] irc_t [5] = '{3'b000, 3'b100, 3'b101, 3'b110, 3'b111};
    logic [1:0] bw_t [5] = '{2'b01, 2'b10, 2'b11, 2'b00, 2'b01};
    // fetch flag, target code and address per entry
    logic [31:0] map_t [24] = '{32'h00000017, 32'h01000018, 32'h010000FF, 32'h02000100, 32'h020003FF,
        32'h14000010, 32'h140003FF, 32'h03000400, 32'h03FF0400, 32'h03FF05FF, 32'h05001C00, 32'h06001E00,
        32'h06001EFF, 32'h07001F00, 32'h07001FDF, 32'h08001FE0, 32'h0AFF2010, 32'h09002100,
        32'h0BFF0080, 32'h04FF0200, 32'h04FF1000, 32'h04000800, 32'h04050000, 32'h0A002010};

    boot_config_and_address_decode i_dut (.clk, .reset, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .cpu_addr, .cpu_fetch,
        .cpu_direct, .large_package, .external_fetch_pin, .powerdown_req, .watchdog_disable_req,
        .target, .addr_fault, .ext_addr, .cfg_rd_req, .cfg_rd_addr, .cfg_rd_valid, .cfg_rd_data,
        .cfg_done, .single_write_strobe, .addr_latch_pulse, .read_protect, .write_protect,
        .wait_limit, .wait_unlimited, .bus_timing_mode3, .bus_16_fixed, .bus_8_fixed, .bus_pin_sized,
        .bus_code_bad, .watchdog_locked, .watchdog_run, .addr_wide, .powerdown_go);
    cfg_rom_model i_rom (.clk, .reset, .slow, .b0, .b1, .b2, .cfg_rd_req, .cfg_rd_addr,
        .cfg_rd_valid, .cfg_rd_data, .n_req);

    // ==========================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one bus access held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= 32'h0000005A;
        avs_read <= ~wr;
        avs_write <= wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // reset with new configuration bytes and wait for the load
    task automatic boot(input logic [7:0] x0, input logic [7:0] x1, input logic [7:0] x2, input logic s);
        @(posedge clk);
        b0 <= x0;
        b1 <= x1;
        b2 <= x2;
        slow <= s;
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        repeat (40) if (cfg_done !== 1'b1) @(posedge clk);
        check(32'(cfg_done), 32'h1);
    endtask
    task automatic dec(input logic [23:0] a, input logic f, input logic [3:0] t);
        cpu_addr <= a;
        cpu_fetch <= f;
        repeat (2) @(posedge clk);
        check(32'(target), 32'(t));
        if (!f) check(32'(addr_fault), 32'(cpu_direct & a >= 24'h100 & a <= 24'h3FF));
    endtask
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ==========================================
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ==========================================
    // main sequence
    initial begin
        logic [2:0] irc;
        logic [1:0] bw;
        logic [7:0] x0, x1, x2;
        logic third, rm;
        {reset, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = {3'b100, 40'h0, 4'hF};
        {cpu_addr, cpu_fetch, cpu_direct, large_package} = 27'h0;
        {external_fetch_pin, powerdown_req, watchdog_disable_req, slow} = 4'b1110;
        {b0, b1, b2} = 24'hFFFFFF;
        for (int i = 0; i < 5; i++) begin
            irc = irc_t[i];
            bw = bw_t[i];
            third = ~i[0];
            x0 = {i[1:0], irc[1:0], i[1], i[0], bw[0], i[0]};
            x1 = {i[1], i[1], 2'b01, i[0], bw[1], irc[2], third};
            x2 = {5'h1F, ~i[1], 2'b10};
            rm = third ? ~i[1] : 1'b1;
            // vary the requests so both gates of each output are exercised
            powerdown_req <= ~i[1];
            watchdog_disable_req <= i[1];
            boot(x0, x1, x2, i[0]);
            b0 <= ~x0;
            bus(1'b0, 8'h00);
            check(rd, {24'h0, x0});
            bus(1'b0, 8'h04);
            check(rd, {24'h0, x1});
            bus(1'b0, 8'h08);
            check(rd, {24'h0, third ? x2 : 8'hFD});
            check(32'(n_req), third ? 32'h3 : 32'h2);
            bus(1'b0, 8'h0C);
            check(rd, 32'({1'b1, ~i[0], bw == 2'b00, i[1], third, 1'b1}));
            check(32'({single_write_strobe, addr_latch_pulse, write_protect, read_protect}),
                32'({i[0], i[1], ~i[1], ~i[0]}));
            check(32'({wait_unlimited, bus_timing_mode3, watchdog_locked, watchdog_run, powerdown_go}),
                32'({irc == 3'b111, i[1], ~i[0], ~i[0] | ~i[1], i[0] & ~i[1]}));
            check(32'({bus_16_fixed, bus_8_fixed, bus_pin_sized, bus_code_bad}),
                32'({bw == 2'b01, bw == 2'b10, bw == 2'b11, bw == 2'b00}));
            if (i < 4) check(32'(wait_limit), 32'(i));
            dec(24'h023456, 1'b0, boot_cfg_pkg::TGT_EXT);
            check(32'(ext_addr), third ? 32'h023456 : 32'h003456);
            dec(24'h002100, 1'b0, rm ? boot_cfg_pkg::TGT_PROG_INT : boot_cfg_pkg::TGT_EXT);
            dec(24'hFF3000, 1'b0, boot_cfg_pkg::TGT_PROG_INT);
        end
        // writes are ignored and unmapped offsets read the filler word
        bus(1'b1, 8'h00);
        bus(1'b0, 8'h00);
        check(rd, {24'h0, x0});
        bus(1'b0, 8'h20);
        check(rd, 32'hDEADBEEF);
        // full map walk with overlay and direct addressing on
        large_package <= 1'b1;
        cpu_direct <= 1'b1;
        for (int k = 0; k < 24; k++) dec(map_t[k][23:0], map_t[k][28], map_t[k][27:24]);
        dec(24'h3A1234, 1'b0, boot_cfg_pkg::TGT_EXT);
        check(32'(ext_addr), 32'h0F1234);
        external_fetch_pin <= 1'b0;
        repeat (5) @(posedge clk);
        dec(24'h002100, 1'b0, boot_cfg_pkg::TGT_EXT);
        dec(24'hFF3000, 1'b0, boot_cfg_pkg::TGT_EXT);
        tally_and_finish();
    end
endmodule
